/* File: pat_pkg.sv */
/*
  Package for the peak and average telemetry block: command codes,
  field positions, reset values, timing figures and the direct-format
  coefficients that the host applies to the readings.
  Assumes a single 10 MHz clock domain shared by all users.
*/
package pat_pkg;

  // command codes seen on the management command port
  localparam logic [7:0] CMD_PEAK_INPUT_VOLTAGE  = 8'hD1;
  localparam logic [7:0] CMD_PEAK_OUTPUT_CURRENT = 8'hD2;
  localparam logic [7:0] CMD_PEAK_INPUT_POWER    = 8'hD3;
  localparam logic [7:0] CMD_PEAK_TEMPERATURE    = 8'hD4;
  localparam logic [7:0] CMD_PEAK_RESET          = 8'hD5;
  localparam logic [7:0] CMD_AVG_STARTUP_CONFIG  = 8'hDD;
  localparam logic [7:0] CMD_PEAK_OUTPUT_VOLTAGE = 8'hFD;

  // averaging/startup byte layout
  localparam int          CFG_AVG_LSB  = 0;
  localparam int          CFG_AVG_MSB  = 3;
  localparam int          CFG_OCP_LSB  = 4;
  localparam int          CFG_OCP_MSB  = 5;
  localparam logic [5:0]  CFG_RESET    = 6'h00;
  localparam logic [15:0] PEAK_RESET   = 16'h0000;

  // startup overcurrent field codes and their levels in amperes
  localparam logic [1:0] OCP_CODE_16A = 2'h0;
  localparam logic [1:0] OCP_CODE_24A = 2'h1;
  localparam logic [1:0] OCP_CODE_8A  = 2'h2;
  localparam logic [7:0] OCP_AMPS_16  = 8'h10;
  localparam logic [7:0] OCP_AMPS_24  = 8'h18;
  localparam logic [7:0] OCP_AMPS_8   = 8'h08;

  // sample timing
  localparam int CLK_HZ            = 10_000_000;
  localparam int SAMPLE_SLOW_US    = 2000;
  localparam int SAMPLE_FAST_US    = 1000;
  localparam int SAMPLE_SLOW_CYC   = SAMPLE_SLOW_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_FAST_CYC   = SAMPLE_FAST_US * (CLK_HZ / 1_000_000);

  // reading widths
  localparam int READING_BITS = 10;
  localparam int POWER_BITS   = 16;
  localparam int MAX_SHIFT    = 15;

  // direct-format coefficients; resistance-scaled slopes are per milliohm
  // of the external load-reporting resistance, times 1000
  localparam int VOLT_M       = 7578;  // [R8]
  localparam int VOLT_B       = 0;
  localparam int VOLT_R       = -2;
  localparam int TEMP_M       = 205;   // [R9]
  localparam int TEMP_B       = 6545;
  localparam int TEMP_R       = -2;
  localparam int CURR_M_X1000 = 3824;  // [R10]
  localparam int CURR_B       = -4300;
  localparam int CURR_R       = -3;
  localparam int PWR_M_X1000  = 895;   // [R11]
  localparam int PWR_B        = -9100;
  localparam int PWR_R        = -2;
  localparam int EIN_M_X1000  = 3505;  // [R12]
  localparam int EIN_B        = 0;
  localparam int EIN_R        = -5;

  // channel order inside the averaging bank
  typedef enum logic [2:0] {
    CH_VIN  = 3'b000,
    CH_VOUT = 3'b001,
    CH_IOUT = 3'b010,
    CH_PIN  = 3'b011,
    CH_TEMP = 3'b100
  } pat_chan_type;
  localparam int NUM_CH = 5;

  // one management command from the bus engine
  typedef struct packed {
    logic       write;
    logic       send;
    logic       read;
    logic [7:0] code;
    logic [7:0] data;
  } pat_cmd_type;

  // raw converter samples, all on this clock
  typedef struct packed {
    logic [9:0]  vin;
    logic [9:0]  vout;
    logic [9:0]  iout;
    logic [15:0] pin;
    logic [9:0]  temp;
  } pat_sample_type;

endpackage

/* File: pat_averager.sv */
/*
  One averaging channel: sums 2**n samples and divides by a right shift.
  Assumes sample_tick is a one-cycle pulse on clk and that n only
  changes between windows or is allowed to restart the window.
*/
module pat_averager #(
  parameter int WIDTH = 16
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               sample_tick,
  input  wire logic [3:0]         avg_shift,
  input  wire logic signed [WIDTH-1:0] sample,
  output logic signed [WIDTH-1:0] average,
  output logic                    average_valid
);
  import pat_pkg::*;

  localparam int SUM_BITS = WIDTH + MAX_SHIFT;

  logic signed [SUM_BITS-1:0] sum;
  logic [MAX_SHIFT:0]         count;
  logic [3:0]                 shift_seen;
  logic [MAX_SHIFT:0]         target;
  logic                       window_done;
  logic                       shift_changed;
  logic signed [SUM_BITS-1:0] sum_next;
  logic signed [SUM_BITS-1:0] quotient;

  // window length and completion; a changed setting restarts the window
  assign target        = (MAX_SHIFT+1)'(1) << avg_shift;
  assign shift_changed = shift_seen != avg_shift;
  assign sum_next      = sum + SUM_BITS'(sample);
  assign window_done   = sample_tick && (count + 1'b1 == target);
  assign quotient      = sum_next >>> avg_shift; // power-of-two divide [R17]

  // accumulate; the average is loaded once the window is full [R5] [R17]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sum           <= '0;
      count         <= '0;
      shift_seen    <= '0;
      average       <= '0;
      average_valid <= 1'b0;
    end else begin
      shift_seen    <= avg_shift;
      average_valid <= window_done && !shift_changed;
      if (shift_changed) begin
        sum   <= '0;
        count <= '0;
      end else if (window_done) begin
        sum     <= '0;
        count   <= '0;
        average <= quotient[WIDTH-1:0];
      end else if (sample_tick) begin
        sum   <= sum_next;
        count <= count + 1'b1;
      end
    end
  end
endmodule

/* File: pat_telemetry.sv */
/*
  Peak and average telemetry for a 12 V protection switch.
  Holds the averaging/startup byte, averages four converter channels,
  passes temperature through one-sample windows and keeps all five
  peaks, answering management commands by code.
  Assumes a bus engine on the same clock delivers decoded commands as
  one-cycle strobes and takes the read answer one cycle later.
  Assumes converter samples arrive already in direct format on this
  clock, so no synchroniser sits on them; the sample timers run free
  from reset.
*/
// Summary of operation
// [R1] five 16-bit peak registers hold maxima, 10-bit except power
// [R2] code D5h or power cycle clears peaks
// [R3] peaks at D1h, D2h, D3h, D4h, FDh
// [R4] bits 5:4 pick 16A, 24A, 8A startup
// [R5] average 2**n samples, 2ms or 1ms each
// [R6] ten-bit readings, power sixteen-bit two's complement
// [R7] host converts reading with slope, offset, exponent
// [R8] voltage slope 7578, offset 0, exponent -2
// [R9] temperature slope 205, offset 6545, exponent -2
// [R10] current slope 3.824 times resistance, exponent -3
// [R11] power slope 0.895 times resistance, exponent -2
// [R12] energy slope 3.505 times resistance, exponent -5
// [R13] current readings continue with switch off
// [R14] config byte uses bits 5:0 only
// [R15] sample count governs voltage, current, power
// [R16] peak replaced only by larger reading, resets zero
// [R17] average updates per window by right shift
module pat_telemetry #(
  parameter int SLOW_CYCLES = pat_pkg::SAMPLE_SLOW_CYC,
  parameter int FAST_CYCLES = pat_pkg::SAMPLE_FAST_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire pat_pkg::pat_cmd_type    cmd,
  input  wire pat_pkg::pat_sample_type samples,
  output logic [15:0]                  read_data,
  output logic                         read_valid,
  output logic                         read_hit,
  output logic [7:0]                   startup_overcurrent_amps,
  output logic                         startup_overcurrent_valid,
  output logic [15:0]                  avg_vin,
  output logic [15:0]                  avg_vout,
  output logic [15:0]                  avg_iout,
  output logic [15:0]                  avg_pin,
  output logic [15:0]                  avg_temp
);
  import pat_pkg::*;

  localparam int SLOW_W = $clog2(SLOW_CYCLES);
  localparam int FAST_W = $clog2(FAST_CYCLES);

  logic [5:0]        config_bits;
  logic [SLOW_W-1:0] slow_count;
  logic [FAST_W-1:0] fast_count;
  logic              slow_tick;
  logic              fast_tick;
  logic [15:0]       peak [NUM_CH];
  logic [15:0]       chan_in [NUM_CH];
  logic [15:0]       chan_avg [NUM_CH];
  logic [NUM_CH-1:0] chan_valid;
  logic [NUM_CH-1:0] chan_tick;
  logic [3:0]        chan_shift [NUM_CH];
  logic [NUM_CH-1:0] chan_signed;
  logic              cfg_write;
  logic              peak_clear;
  logic [3:0]        avg_sel;
  logic [1:0]        ocp_sel;
  logic [15:0]       lookup;
  logic              lookup_hit;

  // compare two readings; only power is two's complement
  // one shared comparator keeps the clear path and the update path alike
  function automatic logic is_greater(input logic [15:0] a,
                                      input logic [15:0] b,
                                      input logic        sgn);
    is_greater = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  // readings leave this block unscaled; the host turns them into real
  // units with fixed direct-format coefficients, kept as package
  // constants so host models and firmware share one copy:
  //   voltages: slope 7578, offset 0, exponent -2               [R8]
  //   temperature: slope 205, offset 6545, exponent -2          [R9]
  //   current: slope 3.824 per unit load resistance, offset
  //     -4300, exponent -3                                      [R10]
  //   power: slope 0.895 per unit load resistance, offset
  //     -9100, exponent -2                                      [R11]
  //   energy: slope 3.505 per unit load resistance, offset 0,
  //     exponent -5; no energy sum is kept here, so a host that
  //     wants energy must accumulate power readings itself      [R12]

  // command decode
  assign cfg_write  = cmd.write && cmd.code == CMD_AVG_STARTUP_CONFIG;
  assign peak_clear = cmd.send && cmd.code == CMD_PEAK_RESET;     // [R2]
  assign avg_sel    = config_bits[CFG_AVG_MSB:CFG_AVG_LSB];
  assign ocp_sel    = config_bits[CFG_OCP_MSB:CFG_OCP_LSB];

  // startup level; code 11 is unused and flagged as not valid
  assign startup_overcurrent_amps =
      (ocp_sel == OCP_CODE_16A) ? OCP_AMPS_16 :                   // [R4]
      (ocp_sel == OCP_CODE_24A) ? OCP_AMPS_24 :
      (ocp_sel == OCP_CODE_8A)  ? OCP_AMPS_8  : 8'h00;
  assign startup_overcurrent_valid = ocp_sel != 2'h3;

  // averaging/startup byte; the top two bits are not stored [R14] [R15]
  // a host that sets them reads zero back, which shows the write landed
  // in the six effective bits only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_bits <= CFG_RESET;
    end else if (cfg_write) begin
      config_bits <= cmd.data[5:0];
    end
  end

  // sample period timers: 2 ms slow, 1 ms fast [R5]
  // they run free from reset rather than restarting on a config write,
  // so a new sample count starts at the next tick, not at once
  assign slow_tick = slow_count == SLOW_W'(SLOW_CYCLES - 1);
  assign fast_tick = fast_count == FAST_W'(FAST_CYCLES - 1);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_count <= '0;
      fast_count <= '0;
    end else begin
      slow_count <= slow_tick ? '0 : slow_count + 1'b1;
      fast_count <= fast_tick ? '0 : fast_count + 1'b1;
    end
  end

  // channel wiring: readings zero-extended from 10 bits, power kept
  // signed [R6]; current is never gated by the switch state, so it
  // keeps reporting while the pass transistor is off [R13]
  // every averager carries a 16-bit word so power keeps its sign; the
  // 10-bit channels only ever fill the low bits
  assign chan_in[CH_VIN]  = {6'h00, samples.vin};
  assign chan_in[CH_VOUT] = {6'h00, samples.vout};
  assign chan_in[CH_IOUT] = {6'h00, samples.iout};
  assign chan_in[CH_PIN]  = samples.pin;
  assign chan_in[CH_TEMP] = {6'h00, samples.temp};
  assign chan_tick   = {slow_tick, slow_tick, fast_tick, slow_tick,
                        slow_tick};
  assign chan_signed = 5'h08;
  // temperature is not averaged: the sample count covers V, I, P [R15]
  assign chan_shift[CH_VIN]  = avg_sel;
  assign chan_shift[CH_VOUT] = avg_sel;
  assign chan_shift[CH_IOUT] = avg_sel;
  assign chan_shift[CH_PIN]  = avg_sel;
  assign chan_shift[CH_TEMP] = 4'h0;

  // one averager and one peak holder per channel
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      pat_averager #(
        .WIDTH(16)
      ) u_avg (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sample_tick  (chan_tick[i]),
        .avg_shift    (chan_shift[i]),
        .sample       (chan_in[i]),
        .average      (chan_avg[i]),
        .average_valid(chan_valid[i])
      );

      // a clear in the same cycle as a new reading restarts the peak
      // from that reading when it is above zero, so the reading is not lost [R2] [R16]
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          peak[i] <= PEAK_RESET;                                  // [R16]
        end else if (peak_clear) begin
          peak[i] <= (chan_valid[i] &&
                      is_greater(chan_avg[i], PEAK_RESET, chan_signed[i]))
                     ? chan_avg[i] : PEAK_RESET;
        end else if (chan_valid[i] &&
                     is_greater(chan_avg[i], peak[i], chan_signed[i])) begin
          peak[i] <= chan_avg[i];                            // [R1] [R16]
        end
      end
    end
  endgenerate

  // averages leave as the registered words of the averagers
  assign avg_vin  = chan_avg[CH_VIN];
  assign avg_vout = chan_avg[CH_VOUT];
  assign avg_iout = chan_avg[CH_IOUT];
  assign avg_pin  = chan_avg[CH_PIN];
  assign avg_temp = chan_avg[CH_TEMP];

  // read map; unknown codes answer zero with read_hit low [R3]
  always_comb begin
    lookup_hit = 1'b1;
    unique case (cmd.code)
      CMD_PEAK_INPUT_VOLTAGE:  lookup = peak[CH_VIN];
      CMD_PEAK_OUTPUT_CURRENT: lookup = peak[CH_IOUT];
      CMD_PEAK_INPUT_POWER:    lookup = peak[CH_PIN];
      CMD_PEAK_TEMPERATURE:    lookup = peak[CH_TEMP];
      CMD_PEAK_OUTPUT_VOLTAGE: lookup = peak[CH_VOUT];
      CMD_AVG_STARTUP_CONFIG:  lookup = {10'h000, config_bits}; // [R14]
      default: begin
        lookup     = 16'h0000;
        lookup_hit = 1'b0;
      end
    endcase
  end

  // registered read answer, one cycle after the request
  // the code is decoded while the strobe stands, so the answer shows the
  // peaks as they stood at the read edge; a peak that moves on that same
  // edge is seen by the next read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_data  <= 16'h0000;
      read_valid <= 1'b0;
      read_hit   <= 1'b0;
    end else begin
      read_valid <= cmd.read;
      read_hit   <= cmd.read && lookup_hit;
      if (cmd.read) begin
        read_data <= lookup;
      end
    end
  end
endmodule

/* File: pat_telemetry_sva.sv */
/*
  Checker for the telemetry block: read answers, config width and the
  startup level decode. Sees only the top module's ports; bound below.
*/
module pat_telemetry_sva (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire pat_pkg::pat_cmd_type cmd,
  input wire logic [15:0]          read_data,
  input wire logic                 read_valid,
  input wire logic                 read_hit,
  input wire logic [7:0]           startup_overcurrent_amps,
  input wire logic                 startup_overcurrent_valid,
  input wire logic [15:0]          avg_vin,
  input wire logic [15:0]          avg_vout,
  input wire logic [15:0]          avg_iout
);
  import pat_pkg::*;
  logic is_peak;
  logic is_map;
  // code decode shared by the read properties
  assign is_peak = cmd.code inside {CMD_PEAK_INPUT_VOLTAGE,
    CMD_PEAK_OUTPUT_CURRENT, CMD_PEAK_INPUT_POWER, CMD_PEAK_TEMPERATURE,
    CMD_PEAK_OUTPUT_VOLTAGE};
  assign is_map = is_peak || (cmd.code == CMD_AVG_STARTUP_CONFIG);
  function automatic logic [7:0] ocp_of(input logic [1:0] c);
    return (c == OCP_CODE_16A) ? OCP_AMPS_16 : (c == OCP_CODE_24A) ?
      OCP_AMPS_24 : (c == OCP_CODE_8A) ? OCP_AMPS_8 : 8'h00;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence peak_read; cmd.read && is_peak; endsequence
  sequence answer_hit; read_valid && read_hit; endsequence
  // code taken at the write edge, level must follow on the next cycle
  property ocp_p;
    logic [1:0] c;
    (cmd.write && cmd.code == CMD_AVG_STARTUP_CONFIG, c = cmd.data[5:4])
      |=> startup_overcurrent_amps == ocp_of(c)
      && startup_overcurrent_valid == (c != 2'h3);
  endproperty
  peak_answer_a: assert property (peak_read |=> answer_hit)
    else $error("peak read not answered");
  read_pulse_a: assert property (!cmd.read |=> !read_valid)
    else $error("answer without read");
  data_hold_a: assert property (!cmd.read |=> $stable(read_data))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (cmd.read && !is_map |=>
    read_valid && !read_hit && read_data == 16'h0000)
    else $error("unmapped read not refused");
  cfg_width_a: assert property (cmd.read && !cmd.code[5] &&
    cmd.code == CMD_AVG_STARTUP_CONFIG |=> read_data[15:6] == 10'h000)
    else $error("config read wider than six bits");
  ocp_level_a: assert property (ocp_p)
    else $error("startup level decode wrong");
  ocp_hold_a: assert property (!cmd.write |=>
    $stable(startup_overcurrent_amps)) else $error("level moved");
  avg_width_a: assert property ({avg_vin[15:10], avg_vout[15:10],
    avg_iout[15:10]} == 18'h00000) else $error("reading over ten bits");
endmodule

bind pat_telemetry pat_telemetry_sva i_pat_telemetry_sva (
  .clk(clk), .sys_rst(sys_rst), .cmd(cmd), .read_data(read_data),
  .read_valid(read_valid), .read_hit(read_hit),
  .startup_overcurrent_amps(startup_overcurrent_amps),
  .startup_overcurrent_valid(startup_overcurrent_valid),
  .avg_vin(avg_vin), .avg_vout(avg_vout), .avg_iout(avg_iout));

/* File: pat_host_model.sv */
/*
  Management host model: issues one decoded command strobe per call.
  Assumes the block takes the strobe on the next rising edge of clk.
*/
module pat_host_model (
  input wire logic             clk,
  output pat_pkg::pat_cmd_type cmd
);
  import pat_pkg::*;
  initial cmd = '0;
  // host-side conversion of a direct-format reading into thousandths
  // of a unit: X = (Y * 10**-R - b) / m, all terms signed
  function automatic int to_milli(input int y, input int m, input int b,
                                  input int r);
    int scale;
    scale = 1;
    for (int i = 0; i < -r; i++) scale = scale * 10;
    return (y * scale - b) * 1000 / m;
  endfunction
  // kind is {write, send, read}; held one full cycle, then released,
  // so back-to-back calls never assign the strobe twice in one step
  task automatic issue(input logic [2:0] kind, input logic [7:0] code,
                       input logic [7:0] data);
    @(posedge clk);
    #1;
    cmd = '{write: kind[2], send: kind[1], read: kind[0],
            code: code, data: data};
    @(posedge clk);
    #1;
    cmd = '0;
  endtask
endmodule

/* File: pat_telemetry_tb_top.sv */
/*
  Testbench for the telemetry block with shortened sample periods.
  Assumes the host model drives cmd; reads are checked from a queue.
*/
module pat_telemetry_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pat_pkg::*;
  localparam logic [7:0] PK_CODE [5] = '{CMD_PEAK_INPUT_VOLTAGE,
    CMD_PEAK_OUTPUT_VOLTAGE, CMD_PEAK_OUTPUT_CURRENT,
    CMD_PEAK_INPUT_POWER, CMD_PEAK_TEMPERATURE};
  localparam logic [7:0] AMPS [4] = '{OCP_AMPS_16, OCP_AMPS_24,
    OCP_AMPS_8, 8'h00};
  logic           clk;
  logic           sys_rst;
  pat_cmd_type    cmd;
  pat_sample_type samples;
  logic [15:0]    read_data;
  logic [15:0]    avg [5];
  logic           read_valid;
  logic           read_hit;
  logic           ocp_valid;
  logic [7:0]     ocp_amps;
  logic [16:0]    exp_q [$];
  logic [16:0]    exp_note;
  logic [15:0]    pk [5];
  logic [15:0]    cur [5];
  logic [31:0]    r;
  logic [31:0]    r2;
  int             err_total;
  int             checks_done;
  int             seed;

  pat_host_model i_pat_host_model (.clk(clk), .cmd(cmd));
  pat_telemetry #(.SLOW_CYCLES(20), .FAST_CYCLES(10)) i_pat_telemetry (
    .clk(clk), .sys_rst(sys_rst), .cmd(cmd), .samples(samples),
    .read_data(read_data), .read_valid(read_valid), .read_hit(read_hit),
    .startup_overcurrent_amps(ocp_amps),
    .startup_overcurrent_valid(ocp_valid), .avg_vin(avg[0]),
    .avg_vout(avg[1]), .avg_iout(avg[2]), .avg_pin(avg[3]),
    .avg_temp(avg[4]));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // note the expected answer, then let the host ask for it
  task automatic rd(input logic [7:0] c, input logic [15:0] e,
                    input logic h);
    exp_q.push_back({h, e});
    i_pat_host_model.issue(3'b001, c, 8'h00);
  endtask

  // answers pulse for one cycle, so each is taken at its own edge
  always @(posedge clk) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(~read_data, read_data);
      else begin
        exp_note = exp_q.pop_front();
        chk({15'h0000, exp_note[16]}, {15'h0000, read_hit});
        chk(exp_note[15:0], read_data);
      end
    end
  end

  // a hang is cut short here and counted as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    seed = 76;
    err_total = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    samples = '0;
    pk = '{default: 16'h0000};
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    foreach (PK_CODE[i]) rd(PK_CODE[i], 16'h0000, 1'b1);
    rd(CMD_AVG_STARTUP_CONFIG, 16'h0000, 1'b1);
    rd(8'h00, 16'h0000, 1'b0);
    i_pat_host_model.issue(3'b100, CMD_PEAK_INPUT_VOLTAGE, 8'hFF);
    rd(CMD_PEAK_INPUT_VOLTAGE, 16'h0000, 1'b1);
    $display("test reset and refusals done");
    // every startup code, with the ignored top bits set
    for (int c = 0; c < 4; c++) begin
      i_pat_host_model.issue(3'b100, CMD_AVG_STARTUP_CONFIG,
                             {2'b11, c[1:0], 4'h0});
      chk({8'h00, AMPS[c]}, {8'h00, ocp_amps});
      chk({15'h0000, c != 3}, {15'h0000, ocp_valid});
      rd(CMD_AVG_STARTUP_CONFIG, {10'h000, c[1:0], 4'h0}, 1'b1);
    end
    i_pat_host_model.issue(3'b100, CMD_AVG_STARTUP_CONFIG, 8'h00);
    // host-side conversion of two readings, worked out by hand
    chk(16'(i_pat_host_model.to_milli(758, VOLT_M, VOLT_B, VOLT_R)),
        16'h2712);
    chk(16'(i_pat_host_model.to_milli(0, CURR_M_X1000, CURR_B,
        CURR_R)), 16'h0464);
    $display("test config done");
    // random readings with one-sample averaging; peaks keep the maxima
    for (int k = 0; k < 5; k++) begin
      r = $random(seed);
      r2 = $random(seed);
      cur = '{{6'h00, r[9:0]}, {6'h00, r[19:10]}, {6'h00, r[29:20]},
              r2[15:0], {6'h00, r2[25:16]}};
      samples = '{vin: cur[0][9:0], vout: cur[1][9:0],
                  iout: cur[2][9:0], pin: cur[3], temp: cur[4][9:0]};
      // power is two's complement, so its peak follows signed order
      foreach (cur[j])
        if (j == 3 ? $signed(cur[j]) > $signed(pk[j]) : cur[j] > pk[j])
          pk[j] = cur[j];
      repeat (45) @(posedge clk);
      #1;
      foreach (cur[j]) chk(cur[j], avg[j]);
    end
    foreach (PK_CODE[i]) rd(PK_CODE[i], pk[i], 1'b1);
    $display("test peaks done");
    samples = '0;
    repeat (45) @(posedge clk);
    i_pat_host_model.issue(3'b010, CMD_PEAK_RESET, 8'h00);
    foreach (PK_CODE[i]) rd(PK_CODE[i], 16'h0000, 1'b1);
    $display("test clear done");
    // four-sample windows over an AABB pattern average to 0x200
    i_pat_host_model.issue(3'b100, CMD_AVG_STARTUP_CONFIG, 8'h02);
    for (int k = 0; k < 16; k++) begin
      samples.vin = k[0] ? 10'h001 : 10'h3FF;
      repeat (40) @(posedge clk);
      #1;
    end
    chk(16'h0200, avg[0]);
    rd(CMD_PEAK_INPUT_VOLTAGE, 16'h0200, 1'b1);
    $display("test averaging done");
    // a second reset stands for a power cycle; the last answer is
    // collected first so reset does not swallow it
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(CMD_PEAK_INPUT_VOLTAGE, 16'h0000, 1'b1);
    rd(CMD_AVG_STARTUP_CONFIG, 16'h0000, 1'b1);
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0) err_total++;
    $display("test power cycle done");
    test_done();
  end
endmodule
